// ==== cwdt_pkg.sv ====
// package: constants and types shared by the watchdog design files
package cwdt_pkg;

  // counter chain geometry
  localparam int CWDT_PRESC_W = 12;
  localparam int CWDT_CNT_W = 6;
  localparam int CWDT_CHAIN_W = CWDT_PRESC_W + CWDT_CNT_W;
  localparam int CWDT_SVC_CLR_LSB = 4;

  // terminal counts: 2^18 - 2^4 and 2^13 - 2^4 oscillator cycles
  localparam logic [17:0] CWDT_TC_LONG = 18'h3_fff0;
  localparam logic [17:0] CWDT_TC_SHORT = 18'h0_1ff0;

  // timing counts in oscillator cycles (clk_sys is the oscillator clock)
  localparam int CWDT_RST_HOLD = 32;
  localparam int CWDT_POR_DELAY = 4096;

  // register indices; byte address is four times the index
  localparam logic [15:0] CWDT_IDX_SERVICE = 16'hffff;
  localparam logic [15:0] CWDT_IDX_OPTION = 16'hfffd;
  localparam logic [15:0] CWDT_IDX_STATUS = 16'hfffe;
  localparam logic [17:0] CWDT_ADDR_SERVICE = {CWDT_IDX_SERVICE, 2'b00};
  localparam logic [17:0] CWDT_ADDR_OPTION = {CWDT_IDX_OPTION, 2'b00};
  localparam logic [17:0] CWDT_ADDR_STATUS = {CWDT_IDX_STATUS, 2'b00};

  // option register fields
  localparam int CWDT_OPT_DIS_BIT = 0;
  localparam int CWDT_OPT_RATE_BIT = 1;
  localparam int CWDT_OPT_STOPEN_BIT = 2;
  localparam logic [2:0] CWDT_OPT_RESET = 3'h0;

  // status register fields
  localparam int CWDT_ST_CAUSE_BIT = 0;
  localparam int CWDT_ST_CNT_LSB = 8;
  localparam logic CWDT_CAUSE_RESET = 1'b0;

  // reset vector low byte default; value is arbitrary
  localparam logic [7:0] CWDT_VEC_LO_DEF = 8'h00;

  // option bits as they travel through the design
  typedef struct packed {
    logic stop_en;
    logic rate_sel;
    logic disable_wd;
  } cwdt_opt_s;

endpackage : cwdt_pkg

// ==== cwdt_chain.sv ====
// prescaler plus counter chain with selective clear masks
`timescale 1ns/1ps
module cwdt_chain
  import cwdt_pkg::*;
#(
  parameter int PW = CWDT_PRESC_W,
  parameter int CW = CWDT_CNT_W
)(
  input wire logic clk_sys, // oscillator clock
  input wire logic reset_n, // async reset, active low
  input wire logic count_en, // advance chain this cycle
  input wire logic clr_presc, // clear prescaler stages
  input wire logic clr_upper, // clear counter and upper prescaler
  input wire logic clr_all, // clear whole chain
  output logic [PW+CW-1:0] value_ff // chain value
);

  logic [PW+CW-1:0] keep;
  logic clr_any;

  // build the keep mask; clears combine, whole clear dominates
  always_comb
  begin
    keep = '1;
    if (clr_presc)
    begin
      keep[PW-1:0] = '0;
    end
    if (clr_upper)
    begin
      keep[PW+CW-1:CWDT_SVC_CLR_LSB] = '0;
    end
    if (clr_all)
    begin
      keep = '0;
    end
  end

  assign clr_any = clr_presc | clr_upper | clr_all;

  // a clear cycle does not also count, so cleared stages read zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      value_ff <= '0;
    end
    else if (clr_any)
    begin
      value_ff <= value_ff & keep;
    end
    else if (count_en)
    begin
      value_ff <= value_ff + 1'b1;
    end
  end

endmodule : cwdt_chain

// ==== cwdt_countdown.sv ====
// one-shot countdown: busy for LOAD cycles after start, then a done pulse
`timescale 1ns/1ps
module cwdt_countdown
  import cwdt_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int LOAD = CWDT_POR_DELAY
)(
  input wire logic clk_sys, // oscillator clock
  input wire logic reset_n, // async reset, active low
  input wire logic start, // one-cycle start pulse
  output logic busy_ff, // high while counting
  output logic done_ff // one-cycle pulse at the end
);

  logic [WIDTH-1:0] cnt_ff;

  // restart wins over a running count
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= '0;
    end
    else if (start)
    begin
      busy_ff <= 1'b1;
      cnt_ff <= WIDTH'(LOAD - 1);
    end
    else if (busy_ff)
    begin
      if (cnt_ff == '0)
      begin
        busy_ff <= 1'b0;
      end
      else
      begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // end-of-count pulse
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= busy_ff & (cnt_ff == '0) & ~start;
    end
  end

endmodule : cwdt_countdown

// ==== cwdt_top.sv ====
// watchdog top: chain control, timeout reset, avalon-mm register slave
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps

// Functional notes
// R1: 12-bit prescaler feeds free-running 6-bit counter
// R2: timeout after 2^13-16 or 2^18-16 cycles
// R3: timeout holds reset low 32 cycles, sets cause
// R4: stop instruction clears whole prescaler
// R5: service write clears counter and prescaler bits 4-11
// R6: service at top address; read returns vector byte
// R7: prescaler cleared 4096 cycles after power-up
// R8: internal reset clears prescaler and counter
// R9: reset vector fetch clears the prescaler
// R10: disable follows option register disable bit
// R11: rate select follows option register rate bit
// R12: no interrupt request, only reset on timeout
// R13: monitor mode plus high voltage disables watchdog
// R14: keeps counting in wait; software services it
// R15: stop mode gates clock and clears prescaler
// R16: software services around stop for full period
// R17: stop-enable bit decides if stop takes effect
// R18: break plus high voltage on reset disables
// R19: disable suppresses all; rate 0 is long period
// R20: each service write clears exactly once
module cwdt_top
  import cwdt_pkg::*;
#(
  parameter logic [17:0] TC_LONG = CWDT_TC_LONG,
  parameter logic [17:0] TC_SHORT = CWDT_TC_SHORT,
  parameter int POR_DELAY = CWDT_POR_DELAY,
  parameter logic [7:0] RESET_VEC_LO = CWDT_VEC_LO_DEF
)(
  input wire logic clk_sys, // oscillator clock, 40 MHz
  input wire logic reset_n, // async reset, active low
  input wire logic [17:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall, high until answer
  input wire logic internal_reset, // system internal reset
  input wire logic vector_fetch, // reset vector fetch pulse
  input wire logic stop_insn, // stop instruction executed
  input wire logic stop_mode, // device in stop mode
  input wire logic monitor_mode, // device in monitor mode
  input wire logic break_state, // break interrupt active
  input wire logic irq_pin_high_voltage, // high level on irq pin
  input wire logic rst_pin_high_voltage, // high level on reset pin
  output logic rst_out_n // watchdog reset, active low
);

  localparam int HOLD_W = 6;
  localparam int POR_W = 13;

  cwdt_opt_s opt_ff;
  logic cause_ff;
  logic waitreq_ff;
  logic [31:0] rdata_ff;
  logic rst_n_ff;
  logic por_arm_ff;
  logic [CWDT_CHAIN_W-1:0] chain;
  logic req;
  logic take;
  logic hit_svc;
  logic hit_opt;
  logic hit_st;
  logic svc_wr;
  logic opt_wr;
  logic cause_clr;
  logic dis_eff;
  logic stop_ok;
  logic cnt_en;
  logic timeout;
  logic stop_clr;
  logic clr_presc;
  logic clr_all;
  logic [17:0] tc_sel;
  logic hold_busy;
  logic por_done;

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign rst_out_n = rst_n_ff;

  // bus decode; a request commits when waitrequest is sampled low
  assign req = avs_read | avs_write;
  assign take = req & ~waitreq_ff;
  assign hit_svc = (avs_address == CWDT_ADDR_SERVICE); // R6
  assign hit_opt = (avs_address == CWDT_ADDR_OPTION);
  assign hit_st = (avs_address == CWDT_ADDR_STATUS);

  // any data value services; the bus write is a single committed cycle
  assign svc_wr = take & avs_write & hit_svc & avs_byteenable[0]; // R5 R20
  assign opt_wr = take & avs_write & hit_opt & avs_byteenable[0];
  assign cause_clr = take & avs_write & hit_st & avs_byteenable[0]
                     & avs_writedata[CWDT_ST_CAUSE_BIT];

  // one wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitreq_ff <= 1'b1;
    end
    else
    begin
      waitreq_ff <= ~(req & waitreq_ff);
    end
  end

  // read data are captured in the stall cycle so they stand at commit
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (avs_read & waitreq_ff)
    begin
      rdata_ff <= 32'h0000_0000;
      if (hit_svc)
      begin
        rdata_ff[7:0] <= RESET_VEC_LO; // R6
      end
      else if (hit_opt)
      begin
        rdata_ff[2:0] <= opt_ff;
      end
      else if (hit_st)
      begin
        rdata_ff[CWDT_ST_CAUSE_BIT] <= cause_ff;
        rdata_ff[CWDT_ST_CNT_LSB +: CWDT_CNT_W] <=
          chain[CWDT_CHAIN_W-1:CWDT_PRESC_W];
      end
    end
  end

  // option register drives the disable and rate select inputs
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      opt_ff <= CWDT_OPT_RESET;
    end
    else if (opt_wr)
    begin
      opt_ff.disable_wd <= avs_writedata[CWDT_OPT_DIS_BIT]; // R10
      opt_ff.rate_sel <= avs_writedata[CWDT_OPT_RATE_BIT]; // R11
      opt_ff.stop_en <= avs_writedata[CWDT_OPT_STOPEN_BIT]; // R17
    end
  end

  // reset cause flag: a timeout in the clearing cycle still sets it
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cause_ff <= CWDT_CAUSE_RESET;
    end
    else if (timeout)
    begin
      cause_ff <= 1'b1; // R3
    end
    else if (cause_clr)
    begin
      cause_ff <= 1'b0;
    end
  end

  // effective disable: option bit or high voltage in monitor/break
  assign dis_eff = opt_ff.disable_wd // R19
                   | (monitor_mode & (irq_pin_high_voltage
                                      | rst_pin_high_voltage)) // R13
                   | (break_state & rst_pin_high_voltage); // R18

  // stop only takes effect when the stop-enable option allows it
  assign stop_ok = opt_ff.stop_en; // R17
  assign stop_clr = stop_insn & stop_ok; // R4 R15

  // there is no wait input: wait mode leaves counting untouched
  assign cnt_en = ~dis_eff & ~(stop_mode & stop_ok) // R14 R15
                  & ~hold_busy;

  // rate select 0 picks the long period
  assign tc_sel = opt_ff.rate_sel ? TC_SHORT : TC_LONG; // R19 R11

  // overflow compare on the whole chain; disable blocks the reset too
  assign timeout = cnt_en & (chain == tc_sel); // R2 R19

  assign clr_presc = stop_clr | vector_fetch | por_done; // R4 R7 R9
  assign clr_all = internal_reset | timeout; // R8

  // prescaler plus counter chain
  cwdt_chain #(
    .PW(CWDT_PRESC_W),
    .CW(CWDT_CNT_W)
  ) u_chain (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .count_en(cnt_en), // R1
    .clr_presc(clr_presc),
    .clr_upper(svc_wr), // R5
    .clr_all(clr_all),
    .value_ff(chain)
  );

  // power-on delay arms once right after reset release
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      por_arm_ff <= 1'b1;
    end
    else
    begin
      por_arm_ff <= 1'b0;
    end
  end

  cwdt_countdown #(
    .WIDTH(POR_W),
    .LOAD(POR_DELAY)
  ) u_por (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(por_arm_ff), // R7
    .busy_ff(),
    .done_ff(por_done)
  );

  // reset pulse length; the watchdog's only action is this reset
  cwdt_countdown #(
    .WIDTH(HOLD_W),
    .LOAD(CWDT_RST_HOLD)
  ) u_hold (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(timeout), // R3 R12
    .busy_ff(hold_busy),
    .done_ff()
  );

  // registered pin drive; lags the hold counter by one cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_n_ff <= 1'b1;
    end
    else
    begin
      rst_n_ff <= ~hold_busy; // R3
    end
  end

  // assertions and their helper logic
  logic [HOLD_W:0] low_cnt_ff;

  // helper: length of the current low stretch on the reset output
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      low_cnt_ff <= '0;
    end
    else if (rst_n_ff)
    begin
      low_cnt_ff <= '0;
    end
    else
    begin
      low_cnt_ff <= low_cnt_ff + 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence rst_low_s;
    (!rst_n_ff)[*8];
  endsequence

  sequence bus_answer_s;
    !waitreq_ff ##1 waitreq_ff;
  endsequence

  rst_start_a: assert property (timeout |-> ##2 rst_low_s) // R3
    else $error("reset output not low after timeout");

  rst_width_a: assert property ($rose(rst_n_ff) |-> low_cnt_ff == 32) // R3
    else $error("reset low stretch is not 32 cycles");

  cause_set_a: assert property (timeout |=> cause_ff) // R3
    else $error("cause bit not set by timeout");

  svc_clear_a: assert property (svc_wr && !internal_reset |=> // R5
    chain[CWDT_CHAIN_W-1:CWDT_SVC_CLR_LSB] == '0)
    else $error("service write did not clear upper chain");

  svc_lowkeep_a: assert property (svc_wr && !clr_presc && !clr_all |=> // R5
    chain[CWDT_SVC_CLR_LSB-1:0] == $past(chain[CWDT_SVC_CLR_LSB-1:0]))
    else $error("service write touched low prescaler stages");

  presc_clear_a: assert property (clr_presc |=> // R4
    chain[CWDT_PRESC_W-1:0] == '0)
    else $error("prescaler not cleared");

  intrst_clear_a: assert property (internal_reset |=> chain == '0) // R8
    else $error("internal reset did not clear chain");

  dis_hold_a: assert property (dis_eff && !clr_presc && !clr_all // R19
    && !svc_wr |=> $stable(chain))
    else $error("chain moved while disabled");

  mon_dis_a: assert property (monitor_mode && rst_pin_high_voltage // R13
    |-> !timeout)
    else $error("timeout while disabled in monitor mode");

  short_rate_a: assert property (timeout && opt_ff.rate_sel // R2
    |-> chain == TC_SHORT)
    else $error("short period timeout at wrong count");

  long_rate_a: assert property (timeout && !opt_ff.rate_sel // R2
    |-> chain == TC_LONG)
    else $error("long period timeout at wrong count");

  vec_read_a: assert property (take && avs_read && hit_svc // R6
    |-> avs_readdata[7:0] == RESET_VEC_LO)
    else $error("service location read is not vector byte");

  bus_ack_a: assert property (req && waitreq_ff |=> bus_answer_s)
    else $error("waitrequest answer not one cycle");

  // the chain must not advance while the reset pulse is being held
  hold_freeze_a: assert property (hold_busy && !clr_presc && !clr_all // R3
    && !svc_wr |=> $stable(chain))
    else $error("chain moved during reset hold");

  // software clear of the cause flag only loses against a timeout
  cause_clr_a: assert property (cause_clr && !timeout |=> !cause_ff) // R3
    else $error("cause bit not cleared by write");

endmodule : cwdt_top

// ==== cwdt_cpu_model.sv ====
// cpu core model: avalon-mm master that reaches the watchdog registers
`timescale 1ns/1ps
module cwdt_cpu_model
  import cwdt_pkg::*;
(
  input wire logic clk_sys, // oscillator clock
  input wire logic avs_waitrequest, // slave stall
  input wire logic [31:0] avs_readdata, // read data
  output logic [17:0] avs_address, // byte address
  output logic avs_read, // read request
  output logic avs_write, // write request
  output logic [31:0] avs_writedata, // write data
  output logic [3:0] avs_byteenable // byte lanes
);
  // idle bus at time zero
  initial
  begin
    avs_address = 18'h0_0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // one transfer; nothing is released before the edge that sees the answer
  task xfer(input logic wr, input logic [17:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released data must not keep showing the last value
    avs_writedata <= ~d;
  endtask : xfer
endmodule : cwdt_cpu_model

// ==== cop_watchdog_timer_test.sv ====
// self-checking bench for the watchdog top with a cpu bus model
`timescale 1ns/1ps
module cop_watchdog_timer_test
  import cwdt_pkg::*;
;
  // shortened counts keep the run brief; low four bits stay zero
  localparam logic [17:0] TCL = 18'h0_0100;
  localparam logic [17:0] TCS = 18'h0_0040;
  localparam int POR = 16;
  localparam logic [7:0] VEC = 8'h5a; // value is arbitrary
  logic clk_sys, reset_n, stop_mode, rst_out_n, avs_read, avs_write;
  logic avs_waitrequest;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [3:0] gate; // monitor, break, irq high voltage, reset high voltage
  logic [2:0] pls; // internal reset, vector fetch, stop instruction
  logic [4:0] dis_tab [5] = '{5'h14, 5'h12, 5'h0a, 5'h0d, 5'h11};
  int n_fail, n_tests, n, hold, seed_v;
  int t_drop; // cycle count since reset release when the reset output fell
  int cyc = 0;
  bit hit, h2;

  cwdt_top #(.TC_LONG(TCL), .TC_SHORT(TCS), .POR_DELAY(POR),
    .RESET_VEC_LO(VEC)) i_cwdt_top (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .internal_reset(pls[2]), .vector_fetch(pls[1]), .stop_insn(pls[0]),
    .stop_mode(stop_mode), .monitor_mode(gate[3]), .break_state(gate[2]),
    .irq_pin_high_voltage(gate[1]), .rst_pin_high_voltage(gate[0]),
    .rst_out_n(rst_out_n));

  cwdt_cpu_model i_cwdt_cpu_model (
    .clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

  // 40 mhz oscillator clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // cycles since reset release, for the power-up timing
  always @(posedge clk_sys)
    cyc <= reset_n ? cyc + 1 : 0;

  task check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task wr(input logic [17:0] a, input logic [31:0] d);
    i_cwdt_cpu_model.xfer(1'b1, a, d, 4'hf, q);
  endtask : wr

  task rd(input logic [17:0] a);
    i_cwdt_cpu_model.xfer(1'b0, a, 32'h0000_0000, 4'hf, q);
  endtask : rd

  // any data value services the watchdog
  task svc;
    wr(CWDT_ADDR_SERVICE, $urandom);
  endtask : svc

  // count edges until reset drops or lim runs out, then time the hold
  task run(input int lim, output bit h);
    int k;
    k = 0;
    hold = 0;
    while (k < lim && rst_out_n !== 1'b0)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    n = k;
    t_drop = cyc;
    h = (k < lim);
    while (rst_out_n === 1'b0 && hold < 100)
    begin
      @(posedge clk_sys);
      #1;
      hold++;
    end
  endtask : run

  // hang guard, well above the expected run length
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    close_out;
  end

  initial
  begin
    reset_n = 1'b0;
    stop_mode = 1'b0;
    gate = 4'h0;
    pls = 3'h0;
    n_fail = 0;
    n_tests = 0;
    seed_v = $urandom(13);
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    // register map after reset; reads do not disturb the chain
    rd(CWDT_ADDR_OPTION);
    check("option reset", q, 32'h0000_0000);
    rd(CWDT_ADDR_STATUS);
    check("status reset", q, 32'h0000_0000);
    rd(CWDT_ADDR_SERVICE);
    check("vector low byte", q, {24'h00_0000, VEC});
    rd(18'h0_0100);
    check("unmapped read", q, 32'h0000_0000);
    // first timeout comes late because power-up clears the prescaler
    run(POR + TCL + 40, hit);
    check("power-up period",
      t_drop >= POR + TCL - 2 && t_drop <= POR + TCL + 6, 1);
    check("reset hold", hold, 32);
    rd(CWDT_ADDR_STATUS);
    check("cause set", q[0], 1);
    wr(CWDT_ADDR_STATUS, 32'h0000_0001);
    rd(CWDT_ADDR_STATUS);
    check("cause cleared", q[0], 0);
    // lane 0 off drops the write
    i_cwdt_cpu_model.xfer(1'b1, CWDT_ADDR_OPTION, 32'h0000_0007, 4'he, q);
    rd(CWDT_ADDR_OPTION);
    check("lane off", q, 32'h0000_0000);
    wr(CWDT_ADDR_OPTION, 32'h0000_0002);
    rd(CWDT_ADDR_OPTION);
    check("option rw", q, 32'h0000_0002);
    svc;
    run(TCS + 40, hit);
    check("short period", n >= TCS - 14 && n <= TCS + 3, 1);
    wr(CWDT_ADDR_OPTION, 32'h0000_0000);
    svc;
    run(TCL + 40, hit);
    check("long period", n >= TCL - 14 && n <= TCL + 3, 1);
    // random service gaps shorter than the period never time out
    wr(CWDT_ADDR_OPTION, 32'h0000_0002);
    repeat (10)
    begin
      svc;
      run(10 + $urandom % 30, hit);
      check("serviced", hit, 0);
    end
    wr(CWDT_ADDR_OPTION, 32'h0000_0003);
    svc;
    run(3 * TCS, hit);
    check("option disable", hit, 0);
    wr(CWDT_ADDR_OPTION, 32'h0000_0002);
    // gating conditions, including two that must not disable
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_sys);
      gate <= dis_tab[i][4:1];
      svc;
      run(3 * TCS, hit);
      check("mode gate", hit, dis_tab[i][0]);
      @(posedge clk_sys);
      gate <= 4'h0;
    end
    // repeated clear pulses hold off the timeout; stop needs stop enable
    for (int k = 0; k < 4; k++)
    begin
      wr(CWDT_ADDR_OPTION, k == 2 ? 32'h0000_0006 : 32'h0000_0002);
      svc;
      hit = 0;
      repeat (12)
      begin
        @(posedge clk_sys);
        pls <= (k == 3) ? 3'h1 : 3'h4 >> k;
        @(posedge clk_sys);
        pls <= 3'h0;
        run(18, h2);
        hit = hit | h2;
      end
      check("pulse clear", hit, k == 3);
    end
    wr(CWDT_ADDR_OPTION, 32'h0000_0006);
    svc;
    @(posedge clk_sys);
    stop_mode <= 1'b1;
    run(3 * TCS, hit);
    check("stop gated", hit, 0);
    @(posedge clk_sys);
    stop_mode <= 1'b0;
    svc;
    run(TCS + 40, hit);
    check("after stop", n >= TCS - 14 && n <= TCS + 3, 1);
    wr(CWDT_ADDR_OPTION, 32'h0000_0002);
    svc;
    @(posedge clk_sys);
    stop_mode <= 1'b1;
    run(TCS + 40, hit);
    check("stop not enabled", hit, 1);
    close_out;
  end
endmodule : cop_watchdog_timer_test
